// File: rtl/obd_pkg.sv
// Purpose: shared constants and carriers for the bulk and done-queue pointers
// Assumes: 32-bit register port, byte offsets from the controller base
// Notes: pointers are 16-byte aligned; low nibble always reads zero
package obd_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_BULK_HEAD = 8'h28;
  localparam logic [7:0] OFS_BULK_CURRENT = 8'h2c;
  localparam logic [7:0] OFS_DONE_HEAD = 8'h30;
  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int ADDR_LSB = 4;
  localparam int CTL_BULK_ENABLE_BIT = 5;
  localparam int CMD_BULK_FILLED_BIT = 1;
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;
  localparam logic [27:0] PTR_FIELD_ZERO = 28'h000_0000;
  localparam logic [3:0] LOW_NIBBLE_ZERO = 4'h0;

  // flush state machine, gray coded
  typedef enum logic [1:0] {
    OBD_IDLE = 2'b00,
    OBD_LINK = 2'b01,
    OBD_FLUSH = 2'b10
  } obd_flush_e;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } obd_bus_s;

  // memory write request to descriptor memory or shared area
  typedef struct packed {
    logic valid;
    logic to_shared;
    logic [31:0] addr;
    logic [31:0] data;
  } obd_mem_s;

  // whole module state
  typedef struct packed {
    logic [27:0] bulk_head;
    logic [27:0] bulk_cur;
    logic [27:0] done_head;
    logic [27:0] td_pend;
    obd_flush_e st;
    logic filled_clr;
    logic [31:0] rdata;
    logic rvalid;
    obd_mem_s mem;
  } obd_state_s;
endpackage

// File: rtl/obd_pointers.sv
// Purpose: bulk current pointer and done queue head pointer of the host core
// Assumes: all inputs synchronous to clk_sys; memory accepts one write a cycle
// Notes: one always_comb computes next state, one always_ff stores it
//
// Functional notes
// - current pointer names served bulk descriptor
// - advance after service, resume next frame
// - list end, filled flag clear: nothing
// - list end, filled set: reload, clear flag
// - enabled reads return live pointer value
// - current pointer starts zero, zero ends list
// - completed descriptor link gets done head
// - done head takes completed descriptor address
// - done head flushed to shared area, zeroed
// - done head delivered through shared area
// - 32-bit pointers, bits 31:4, reset zero
// - traversal starts from bulk head register
`timescale 1ns/100ps
module obd_pointers #(
  parameter int PTR_W = 32 // pointer register width
) (
  input wire logic clk_sys, // system clock, 10 MHz
  input wire logic rst, // async reset, active high
  input wire obd_pkg::obd_bus_s bus, // register access request
  output logic [31:0] rdata, // read data, registered
  output logic rvalid, // read data valid pulse
  input wire logic [31:0] ctl_reg, // control register image
  input wire logic [31:0] cmd_status, // command status register image
  output logic filled_clr, // pulse: clear bulk list filled flag
  input wire logic ed_done, // pulse: current descriptor served
  input wire logic [31:0] ed_next, // next link of served descriptor
  input wire logic td_done, // pulse: transfer descriptor completed
  input wire logic [31:0] td_addr, // address of completed descriptor
  input wire logic frame_start, // pulse: frame boundary
  input wire logic shared_free, // shared done entry consumed
  output obd_pkg::obd_mem_s mem, // memory write request, registered
  input wire logic mem_ready // memory accepts request
);
  // refuse pointer widths the packed fields cannot hold
  if (PTR_W != 32) begin : g_width_chk
    $error("obd_pointers supports only 32-bit pointers");
  end

  obd_pkg::obd_state_s q_ff;
  obd_pkg::obd_state_s nxt_q;
  logic bulk_on;
  logic list_filled;
  logic [2:0] bus_sel;

  // ----------------------------------------------------------------
  // register decode, one-hot, shared by write and read paths
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_decode(input logic [7:0] addr);
    logic [2:0] sel;
    sel = 3'h0;
    if (addr == obd_pkg::OFS_BULK_HEAD) begin
      sel = 3'h1;
    end else if (addr == obd_pkg::OFS_BULK_CURRENT) begin
      sel = 3'h2;
    end else if (addr == obd_pkg::OFS_DONE_HEAD) begin
      sel = 3'h4;
    end
    return sel;
  endfunction

  // control bits and register select
  assign bulk_on = ctl_reg[obd_pkg::CTL_BULK_ENABLE_BIT];
  assign list_filled = cmd_status[obd_pkg::CMD_BULK_FILLED_BIT];
  assign bus_sel = reg_decode(bus.addr);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    nxt_q.rvalid = 1'b0;
    nxt_q.filled_clr = 1'b0;
    // register writes
    if (bus.wr) begin
      if (bus_sel[0]) begin
        nxt_q.bulk_head = bus.wdata[31:obd_pkg::ADDR_LSB];
      end else if (bus_sel[1]) begin
        if (!bulk_on) begin
          nxt_q.bulk_cur = bus.wdata[31:obd_pkg::ADDR_LSB];
        end
      end else if (bus_sel[2]) begin
        nxt_q.done_head = bus.wdata[31:obd_pkg::ADDR_LSB];
      end
    end
    // bulk list walk, pointer survives across frames
    if (ed_done && bulk_on) begin
      nxt_q.bulk_cur = ed_next[31:obd_pkg::ADDR_LSB];
    end else if (bulk_on && q_ff.bulk_cur == obd_pkg::PTR_FIELD_ZERO) begin
      if (list_filled) begin
        nxt_q.bulk_cur = q_ff.bulk_head;
        nxt_q.filled_clr = 1'b1;
      end
    end
    // memory request handshake
    if (q_ff.mem.valid && mem_ready) begin
      nxt_q.mem.valid = 1'b0;
    end
    // done queue sequencing
    case (q_ff.st)
      obd_pkg::OBD_IDLE: begin
        if (td_done) begin
          nxt_q.td_pend = td_addr[31:obd_pkg::ADDR_LSB];
          nxt_q.mem.valid = 1'b1;
          nxt_q.mem.to_shared = 1'b0;
          nxt_q.mem.addr = td_addr;
          nxt_q.mem.data = {q_ff.done_head, obd_pkg::LOW_NIBBLE_ZERO};
          nxt_q.st = obd_pkg::OBD_LINK;
        end else if (frame_start && shared_free &&
                     q_ff.done_head != obd_pkg::PTR_FIELD_ZERO) begin
          nxt_q.mem.valid = 1'b1;
          nxt_q.mem.to_shared = 1'b1;
          nxt_q.mem.addr = obd_pkg::PTR_RESET;
          nxt_q.mem.data = {q_ff.done_head, obd_pkg::LOW_NIBBLE_ZERO};
          nxt_q.st = obd_pkg::OBD_FLUSH;
        end
      end
      obd_pkg::OBD_LINK: begin
        if (q_ff.mem.valid && mem_ready) begin
          nxt_q.done_head = q_ff.td_pend;
          nxt_q.st = obd_pkg::OBD_IDLE;
        end
      end
      obd_pkg::OBD_FLUSH: begin
        if (q_ff.mem.valid && mem_ready) begin
          nxt_q.done_head = obd_pkg::PTR_FIELD_ZERO;
          nxt_q.st = obd_pkg::OBD_IDLE;
        end
      end
      default: begin
        nxt_q.st = obd_pkg::OBD_IDLE;
      end
    endcase
    // register reads, live values, low nibble zero
    if (bus.rd) begin
      nxt_q.rvalid = 1'b1;
      if (bus_sel[0]) begin
        nxt_q.rdata = {q_ff.bulk_head, obd_pkg::LOW_NIBBLE_ZERO};
      end else if (bus_sel[1]) begin
        nxt_q.rdata = {q_ff.bulk_cur, obd_pkg::LOW_NIBBLE_ZERO};
      end else if (bus_sel[2]) begin
        nxt_q.rdata = {q_ff.done_head, obd_pkg::LOW_NIBBLE_ZERO};
      end else begin
        nxt_q.rdata = obd_pkg::PTR_RESET;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign rdata = q_ff.rdata;
  assign rvalid = q_ff.rvalid;
  assign filled_clr = q_ff.filled_clr;
  assign mem = q_ff.mem;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence td_link_s;
    q_ff.st == obd_pkg::OBD_LINK && q_ff.mem.valid && mem_ready;
  endsequence
  sequence flush_s;
    q_ff.st == obd_pkg::OBD_FLUSH && q_ff.mem.valid && mem_ready;
  endsequence

  adv_ptr_a: assert property (@(posedge clk_sys) disable iff (rst)
    ed_done && bulk_on |=> q_ff.bulk_cur == $past(ed_next[31:4]))
    else $error("bulk pointer did not advance");
  no_fill_a: assert property (@(posedge clk_sys) disable iff (rst)
    bulk_on && !ed_done && !list_filled && q_ff.bulk_cur == 28'h000_0000
    && !(bus.wr && bus.addr == obd_pkg::OFS_BULK_CURRENT) |=> !filled_clr
    && q_ff.bulk_cur == 28'h000_0000)
    else $error("action taken with flag clear");
  reload_a: assert property (@(posedge clk_sys) disable iff (rst)
    bulk_on && !ed_done && list_filled && q_ff.bulk_cur == 28'h000_0000
    |=> filled_clr && q_ff.bulk_cur == $past(q_ff.bulk_head))
    else $error("bulk reload missing");
  wr_block_a: assert property (@(posedge clk_sys) disable iff (rst)
    bus.wr && bus.addr == obd_pkg::OFS_BULK_CURRENT && bulk_on && !ed_done
    && q_ff.bulk_cur != 28'h000_0000 |=> $stable(q_ff.bulk_cur))
    else $error("pointer written while enabled");
  live_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
    bus.rd && bus.addr == obd_pkg::OFS_BULK_CURRENT
    |=> rvalid && rdata == {$past(q_ff.bulk_cur), 4'h0})
    else $error("read not live");
  link_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
    q_ff.st == obd_pkg::OBD_IDLE && td_done |=> mem.valid && !mem.to_shared
    && mem.data == {$past(q_ff.done_head), 4'h0} && mem.addr == $past(td_addr))
    else $error("descriptor link wrong");
  head_upd_a: assert property (@(posedge clk_sys) disable iff (rst)
    td_link_s |=> q_ff.done_head == $past(q_ff.td_pend))
    else $error("done head not updated");
  flush_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
    flush_s |=> q_ff.done_head == 28'h000_0000)
    else $error("done head not cleared");
  flush_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    q_ff.st == obd_pkg::OBD_IDLE && !td_done && !(frame_start && shared_free)
    |=> q_ff.st != obd_pkg::OBD_FLUSH)
    else $error("flush outside frame boundary");
  low_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    rvalid |-> rdata[3:0] == 4'h0)
    else $error("low nibble not zero");

  // ----------------------------------------------------------------
  // further checks on pointer, queue and read paths
  // ----------------------------------------------------------------
  // bulk list walk has reached its end with nothing served
  sequence list_end_s;
    bulk_on && !ed_done && q_ff.bulk_cur == 28'h000_0000;
  endsequence
  // completed descriptor taken while the queue is idle
  sequence td_take_s;
    q_ff.st == obd_pkg::OBD_IDLE && td_done;
  endsequence
  // frame boundary with a free shared entry and work to flush
  sequence flush_req_s;
    q_ff.st == obd_pkg::OBD_IDLE && !td_done && frame_start && shared_free
    && q_ff.done_head != 28'h000_0000;
  endsequence
  // everything leaves reset cleared
  reset_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> q_ff.bulk_cur == 28'h000_0000 && q_ff.done_head == 28'h000_0000
    && !rvalid && !mem.valid && !filled_clr)
    else $error("state not cleared by reset");
  // bulk head write lands in the upper field
  head_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
    bus.wr && bus_sel == 3'h1 |=> q_ff.bulk_head == $past(bus.wdata[31:4]))
    else $error("bulk head write lost");
  // current pointer write lands while the list is disabled
  cur_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
    bus.wr && bus_sel == 3'h2 && !bulk_on |=> q_ff.bulk_cur == $past(bus.wdata[31:4]))
    else $error("current pointer write lost");
  // current pointer moves only by write, service or reload
  cur_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !bus.wr && !ed_done && !(bulk_on && list_filled && q_ff.bulk_cur == 28'h000_0000)
    |=> $stable(q_ff.bulk_cur))
    else $error("current pointer moved on its own");
  // service reports are ignored while the list is disabled
  off_walk_a: assert property (@(posedge clk_sys) disable iff (rst)
    ed_done && !bulk_on && !bus.wr |=> $stable(q_ff.bulk_cur))
    else $error("pointer moved while disabled");
  // flag clear only follows a reload at list end
  clr_cause_a: assert property (@(posedge clk_sys) disable iff (rst)
    filled_clr |-> $past(bulk_on) && $past(list_filled) && !$past(ed_done)
    && $past(q_ff.bulk_cur) == 28'h000_0000)
    else $error("flag cleared without reload");
  // list end with the flag clear leaves the pointer at zero
  end_stay_a: assert property (@(posedge clk_sys) disable iff (rst)
    list_end_s ##0 !list_filled |=> q_ff.bulk_cur == 28'h000_0000 && !filled_clr)
    else $error("list end acted with flag clear");
  // completed descriptor is held for the link step
  td_take_a: assert property (@(posedge clk_sys) disable iff (rst)
    td_take_s |=> q_ff.st == obd_pkg::OBD_LINK && q_ff.td_pend == $past(td_addr[31:4]))
    else $error("completed descriptor not taken");
  // flush request carries the done head to the shared area
  flush_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
    flush_req_s |=> mem.valid && mem.to_shared && mem.addr == 32'h0000_0000
    && mem.data == {$past(q_ff.done_head), 4'h0})
    else $error("flush request wrong");
  // a stalled memory request stays unchanged
  mem_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    mem.valid && !mem_ready |=> mem.valid && $stable(mem.addr) && $stable(mem.data)
    && $stable(mem.to_shared))
    else $error("memory request changed while stalled");
  // the queue is busy only while its request is pending
  busy_req_a: assert property (@(posedge clk_sys) disable iff (rst)
    q_ff.st != obd_pkg::OBD_IDLE |-> mem.valid)
    else $error("queue busy without request");
  // idle queue keeps its head unless the driver writes it
  head_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    q_ff.st == obd_pkg::OBD_IDLE && !(bus.wr && bus_sel == 3'h4)
    |=> $stable(q_ff.done_head))
    else $error("done head moved while idle");
  // an accepted flush returns the queue to idle
  flush_end_a: assert property (@(posedge clk_sys) disable iff (rst)
    flush_s |=> q_ff.st == obd_pkg::OBD_IDLE && !mem.valid)
    else $error("flush did not finish");
  // done head reads back its live value
  rd_head_a: assert property (@(posedge clk_sys) disable iff (rst)
    bus.rd && bus_sel == 3'h4 |=> rvalid && rdata == {$past(q_ff.done_head), 4'h0})
    else $error("done head read wrong");
  // unmapped offsets read as zero
  rd_none_a: assert property (@(posedge clk_sys) disable iff (rst)
    bus.rd && bus_sel == 3'h0 |=> rvalid && rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  // read data valid only answers a read
  rd_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    rvalid |-> $past(bus.rd))
    else $error("read valid without a read");
endmodule

// File: tb/obd_mem_model.sv
// Purpose: descriptor memory and shared area seen by the pointer block
// Assumes: one write request at a time, held until accepted
// Notes: slow mode stalls each request for two cycles
`timescale 1ns/100ps
module obd_mem_model (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  input wire obd_pkg::obd_mem_s mem, // write request from the block
  input wire logic slow, // stall each request
  output logic mem_ready, // request accepted this edge
  output logic [31:0] last_addr_ff, // address of last accepted write
  output logic [31:0] last_data_ff, // data of last accepted write
  output logic last_sh_ff // last write went to shared area
);
  logic [1:0] wait_ff;
  // accept at once, or after two stalled cycles
  always_comb mem_ready = mem.valid && (!slow || wait_ff == 2'h2);
  // capture accepted writes, count stalled cycles
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_ff <= 2'h0;
      last_addr_ff <= 32'h0000_0000;
      last_data_ff <= 32'h0000_0000;
      last_sh_ff <= 1'b0;
    end else if (mem_ready) begin
      wait_ff <= 2'h0;
      last_addr_ff <= mem.addr;
      last_data_ff <= mem.data;
      last_sh_ff <= mem.to_shared;
    end else if (mem.valid) begin
      wait_ff <= wait_ff + 2'h1;
    end
  end
endmodule

// File: tb/tb_ohci_bulk_done_pointers.sv
// Purpose: self-checking bench for the bulk and done-queue pointers
// Assumes: inputs change 1 ns after the rising edge
// Notes: memory stalls, then answers at once, in the done queue test
`timescale 1ns/100ps
module tb_ohci_bulk_done_pointers;
  logic clk_sys, rst, rvalid, filled_clr, ed_done, td_done, frame_start, shared_free;
  logic mem_ready, slow, last_sh;
  logic [31:0] rdata, ctl_reg, cmd_status, ed_next, td_addr, last_a, last_d;
  obd_pkg::obd_bus_s bus;
  obd_pkg::obd_mem_s mem;
  int failures, num_checks, cycles;
  obd_pointers obd_pointers_i (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
    .rvalid(rvalid), .ctl_reg(ctl_reg), .cmd_status(cmd_status), .filled_clr(filled_clr),
    .ed_done(ed_done), .ed_next(ed_next), .td_done(td_done), .td_addr(td_addr),
    .frame_start(frame_start), .shared_free(shared_free), .mem(mem), .mem_ready(mem_ready));
  obd_mem_model obd_mem_model_i (.clk_sys(clk_sys), .rst(rst), .mem(mem), .slow(slow),
    .mem_ready(mem_ready), .last_addr_ff(last_a), .last_data_ff(last_d), .last_sh_ff(last_sh));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cyc();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    cyc();
    chk(32'h0000_0001, {31'h0000_0000, rvalid});
    chk(exp, rdata);
    bus.rd = 1'b0;
    cyc();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc();
    bus.wr = 1'b0;
    cyc();
  endtask
  // wait for the memory request to be accepted
  task automatic mem_idle();
    for (int i = 0; i < 20 && mem.valid !== 1'b0; i++) begin
      cyc();
    end
  endtask
  task automatic td(input logic [31:0] a);
    td_done = 1'b1;
    td_addr = a;
    cyc();
    td_done = 1'b0;
    mem_idle();
  endtask
  task automatic served(input logic [31:0] nxt);
    ed_done = 1'b1;
    ed_next = nxt;
    cyc();
    ed_done = 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd_chk(8'h2c, 32'h0000_0000);
    rd_chk(8'h30, 32'h0000_0000);
    rd_chk(8'h34, 32'h0000_0000);
    wr(8'h2c, 32'h1234_5670);
    rd_chk(8'h2c, 32'h1234_5670);
    ctl_reg = 32'h0000_0020;
    wr(8'h2c, 32'h0000_aaa0);
    rd_chk(8'h2c, 32'h1234_5670);
    $display("test regs done");
  endtask
  task automatic t_walk();
    wr(8'h28, 32'h0000_1000);
    rd_chk(8'h28, 32'h0000_1000);
    served(32'h0000_2008);
    rd_chk(8'h2c, 32'h0000_2000);
    served(32'h0000_0000);
    rd_chk(8'h2c, 32'h0000_0000);
    chk(32'h0000_0000, {31'h0000_0000, filled_clr});
    cmd_status = 32'h0000_0002;
    cyc();
    chk(32'h0000_0001, {31'h0000_0000, filled_clr});
    cmd_status = 32'h0000_0000;
    cyc();
    rd_chk(8'h2c, 32'h0000_1000);
    $display("test walk done");
  endtask
  task automatic t_done();
    slow = 1'b1;
    td(32'h0000_3000);
    chk(32'h0000_0000, last_d);
    rd_chk(8'h30, 32'h0000_3000);
    td(32'h0000_4000);
    chk(32'h0000_4000, last_a);
    chk(32'h0000_3000, last_d);
    frame_start = 1'b1;
    cyc();
    frame_start = 1'b0;
    chk(32'h0000_0000, {31'h0000_0000, mem.valid});
    shared_free = 1'b1;
    frame_start = 1'b1;
    cyc();
    frame_start = 1'b0;
    mem_idle();
    chk(32'h0000_0001, {31'h0000_0000, last_sh});
    chk(32'h0000_4000, last_d);
    chk(32'h0000_0000, last_a);
    rd_chk(8'h30, 32'h0000_0000);
    slow = 1'b0;
    td(32'h0000_5000);
    chk(32'h0000_5000, last_a);
    chk(32'h0000_0000, last_d);
    rd_chk(8'h30, 32'h0000_5000);
    $display("test done queue done");
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    {rst, ed_done, td_done, frame_start, shared_free, slow} = 6'h20;
    {ctl_reg, cmd_status, ed_next, td_addr} = 128'h0;
    bus = '0;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    t_regs();
    t_walk();
    t_done();
    end_of_test();
  end
endmodule
